// >>> logic/card_seq_defines.vh
// Timing constants for the smart card reset sequencer
`ifndef CARD_SEQ_DEFINES_VH
`define CARD_SEQ_DEFINES_VH
`define CLK_PERIOD_NS      100
`define CARD_CLK_PERIOD_NS 250
`define CARD_CLK_MIN_NS    200
`define CARD_CLK_MAX_NS    1000
`define RST_HOLD_MIN       40000
`define RST_HOLD_MAX       45000
`define RST_HOLD_TARGET    40100
`define IO_RELEASE_MAX     200
`define IO_RELEASE_AT      2
`define ATR_WIN_MIN        380
`define ATR_WIN_MAX        42000
`define DEACT_START_MS     50
`define DEACT_TOTAL_MS     100
`define DEACT_STEP         40
`endif

// >>> logic/card_clock_gen.v
// Card clock divider: divides the system clock down to the card clock
`include "card_seq_defines.vh"
module card_clock_gen #(
  parameter HALF_CYCLES = 2
) (
  input  wire clk,
  input  wire reset,
  input  wire run,
  output reg  card_clk_q,
  output reg  card_tick_q
);
  reg [7:0] div_q;

  always @(posedge clk) begin
    // A high phase is always finished before the clock parks, so no runt pulse reaches the card
    if (reset || (!run && !card_clk_q)) begin
      div_q       <= 8'h00;
      card_clk_q  <= 1'b0;
      card_tick_q <= 1'b0;
    end else if (div_q == HALF_CYCLES[7:0] - 8'h01) begin
      div_q       <= 8'h00;
      card_clk_q  <= ~card_clk_q;
      // One tick per full card period, on the rising edge
      card_tick_q <= ~card_clk_q;
    end else begin
      div_q       <= div_q + 8'h01;
      card_tick_q <= 1'b0;
    end
  end
endmodule

// >>> logic/card_reset_seq.v
// Smart card reset sequencer: cold and warm reset, answer window, deactivation
// Summary of operation
// - Cold reset holds the card reset contact low 40000 to 45000 card clocks.
// - Cold reset releases the card I/O contact within 200 card clocks.
// - After cold reset, an answer starting 380 to 42000 card clocks is accepted.
// - Warm reset holds the card reset contact 40000 to 45000 card clocks.
// - Warm reset releases the card I/O contact within 200 card clocks.
// - After warm reset, an answer starting 380 to 42000 card clocks is valid.
// - Missing answer starts deactivation within 50 ms; deactivation ends by 100 ms.
`include "card_seq_defines.vh"
module card_reset_seq #(
  parameter CLK_NS      = `CLK_PERIOD_NS,
  parameter CARD_NS     = `CARD_CLK_PERIOD_NS,
  parameter RST_HOLD    = `RST_HOLD_TARGET,
  parameter ATR_MIN     = `ATR_WIN_MIN,
  parameter ATR_MAX     = `ATR_WIN_MAX,
  parameter DEACT_STEP  = `DEACT_STEP
) (
  input  wire clk,
  input  wire reset,
  input  wire cold_start,
  input  wire warm_start,
  input  wire deact_req,
  input  wire card_io_in,
  output reg  card_clock_out,
  output reg  card_reset_contact,
  output reg  card_io_out,
  output reg  card_io_oe,
  output reg  card_vcc_en,
  output reg  busy,
  output reg  atr_ok,
  output reg  atr_timeout,
  output reg  deact_done
);
  //////////////////////////////////////////////////////////////////////////////
  // Half card period in system clocks: 125 ns / 100 ns rounds up to 2 clocks of 100 ns
  localparam HALF = (CARD_NS / 2 + CLK_NS - 1) / CLK_NS;

  //////////////////////////////////////////////////////////////////////////////
  // State encoding
  localparam S_OFF   = 3'd0;
  localparam S_HOLD  = 3'd1;
  localparam S_ATR   = 3'd2;
  localparam S_ON    = 3'd3;
  localparam S_DEACT = 3'd4;

  // Deactivation phases, in the order the contacts go down
  localparam PH_RST  = 2'b00;
  localparam PH_CLK  = 2'b01;
  localparam PH_IO   = 2'b10;
  localparam PH_PWR  = 2'b11;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state and pin synchronisers
  reg  [2:0]  state_q;
  reg  [15:0] cnt_q;
  reg  [1:0]  deact_ph_q;
  reg         io_s1_q;
  reg         io_s2_q;
  reg         clk_run_q;
  reg         io_low_q;
  wire        card_clk;
  wire        tick;
  wire        start_bit;

  //////////////////////////////////////////////////////////////////////////////
  card_clock_gen #(
    .HALF_CYCLES (HALF)
  ) u_clk (
    .clk         (clk),
    .reset       (reset),
    .run         (clk_run_q),
    .card_clk_q  (card_clk),
    .card_tick_q (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Card I/O is a pin, so two flops before use
  always @(posedge clk) begin
    if (reset) begin
      io_s1_q <= 1'b1;
      io_s2_q <= 1'b1;
    end else begin
      io_s1_q <= card_io_in;
      io_s2_q <= io_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Start bit must be seen low on two samples in a row; a single
  // low sample is taken as a glitch on the open-drain line.
  // Costs one system clock of answer latency, far inside the window.
  always @(posedge clk) begin
    if (reset) begin
      io_low_q <= 1'b0;
    end else begin
      io_low_q <= !io_s2_q;
    end
  end

  assign start_bit = io_low_q && !io_s2_q;

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (reset) begin
      state_q            <= S_OFF;
      cnt_q              <= 16'h0000;
      deact_ph_q         <= 2'b00;
      clk_run_q          <= 1'b0;
      card_clock_out     <= 1'b0;
      card_reset_contact <= 1'b0;
      card_io_out        <= 1'b0;
      card_io_oe         <= 1'b1;
      card_vcc_en        <= 1'b0;
      busy               <= 1'b0;
      atr_ok             <= 1'b0;
      atr_timeout        <= 1'b0;
      deact_done         <= 1'b0;
    end else begin
      // Pin copy of the divider, so the card clock leaves from a flop
      card_clock_out <= card_clk;
      atr_ok         <= 1'b0;
      atr_timeout    <= 1'b0;
      deact_done     <= 1'b0;
      // Shared card clock counter; entry to S_HOLD, S_ATR and S_DEACT clears it
      if (tick)
        cnt_q <= cnt_q + 16'h0001;
      case (state_q)
        S_OFF: begin
          if (cold_start || warm_start) begin
            // Warm reset from S_ON keeps power and clock; from off, cold or warm start starts them here
            state_q            <= S_HOLD;
            cnt_q              <= 16'h0000;
            clk_run_q          <= 1'b1;
            card_vcc_en        <= 1'b1;
            card_reset_contact <= 1'b0;
            busy               <= 1'b1;
          end
        end
        S_ON: begin
          if (deact_req) begin
            state_q    <= S_DEACT;
            cnt_q      <= 16'h0000;
            deact_ph_q <= 2'b00;
          end else if (warm_start) begin
            state_q            <= S_HOLD;
            cnt_q              <= 16'h0000;
            card_reset_contact <= 1'b0;
            busy               <= 1'b1;
          end
        end
        S_HOLD: begin
          // Release I/O early, well inside the 200 period bound
          if (tick && cnt_q == `IO_RELEASE_AT)
            card_io_oe <= 1'b0;
          if (tick && cnt_q == RST_HOLD[15:0] - 16'h0001) begin
            state_q            <= S_ATR;
            cnt_q              <= 16'h0000;
            card_reset_contact <= 1'b1;
          end
        end
        S_ATR: begin
          // Start bit is a low level on the I/O line
          if (start_bit && cnt_q >= ATR_MIN[15:0]) begin
            state_q <= S_ON;
            atr_ok  <= 1'b1;
            busy    <= 1'b0;
          end else if (tick && cnt_q == ATR_MAX[15:0]) begin
            // Early noise before the window is ignored, not taken as answer
            state_q     <= S_DEACT;
            cnt_q       <= 16'h0000;
            deact_ph_q  <= 2'b00;
            atr_timeout <= 1'b1;
          end
        end
        S_DEACT: begin
          // Reset, then clock, each DEACT_STEP+1 card clocks on; then I/O, then power, one system clock apart
          if (tick && cnt_q == DEACT_STEP[15:0]) begin
            cnt_q      <= 16'h0000;
            deact_ph_q <= deact_ph_q + 2'b01;
            case (deact_ph_q)
              PH_RST: card_reset_contact <= 1'b0;
              PH_CLK: clk_run_q          <= 1'b0;
              PH_IO: begin
                card_io_oe  <= 1'b1;
                card_io_out <= 1'b0;
              end
              default: begin
                card_vcc_en <= 1'b0;
                state_q     <= S_OFF;
                busy        <= 1'b0;
                deact_done  <= 1'b1;
              end
            endcase
          end else if (!clk_run_q && !card_clk && !card_clock_out) begin
            // Clock parked low at the pin: finish the rest on the system clock,
            // so power never drops under a card clock that is still high
            deact_ph_q <= deact_ph_q + 2'b01;
            case (deact_ph_q)
              PH_IO: begin
                card_io_oe  <= 1'b1;
                card_io_out <= 1'b0;
              end
              PH_PWR: begin
                card_vcc_en <= 1'b0;
                state_q     <= S_OFF;
                busy        <= 1'b0;
                deact_done  <= 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        default: state_q <= S_OFF;
      endcase
    end
  end
endmodule

// >>> verif/card_model.sv
// Behavioural card that answers the reset after a set number of card clocks
module card_model (
  input  wire        clk,
  input  wire        card_clock_out,
  input  wire        card_reset_contact,
  input  wire [15:0] answer_at,
  output logic       pull_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_q = 16'h0000;
  logic        clk_q = 1'h0;
  always @(posedge clk) begin
    clk_q <= card_clock_out;
    cnt_q <= !card_reset_contact ? 16'h0000 : cnt_q + 16'(card_clock_out && !clk_q);
  end
  // Start bit lasts four card clocks, then the pull-up takes the line back
  assign pull_low = card_reset_contact && cnt_q >= answer_at && cnt_q < answer_at + 16'h0004;
endmodule

// >>> verif/card_seq_chk.sv
// Checker on the contact timing of the card reset sequencer
module card_seq_chk #(parameter RST_HOLD = 40100, ATR_MIN = 380, ATR_MAX = 42000) (
  input wire clk,
  input wire reset,
  input wire card_clock_out,
  input wire card_reset_contact,
  input wire card_io_oe,
  input wire card_vcc_en,
  input wire atr_ok,
  input wire atr_timeout,
  input wire deact_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Card clocks in the reset hold, and since its release
  logic [15:0] hold_q, wait_q;
  always @(posedge clk) begin
    hold_q <= card_reset_contact || !card_vcc_en ? 16'h0000 : hold_q + 16'($rose(card_clock_out));
    wait_q <= !card_reset_contact ? 16'h0000 : wait_q + 16'($rose(card_clock_out));
  end
  sequence s_no_answer;
    atr_timeout;
  endsequence
  hold_len_a: assert property (
    $rose(card_reset_contact) |-> hold_q inside {[RST_HOLD-1:RST_HOLD+1]}) else $error("hold");
  io_release_a: assert property ($rose(card_vcc_en) |-> ##[1:800] !card_io_oe)
    else $error("io release");
  clk_high_a: assert property ($rose(card_clock_out) |=> card_clock_out)
    else $error("card clock");
  atr_early_a: assert property (
    atr_ok |-> card_reset_contact && wait_q >= ATR_MIN) else $error("early answer");
  atr_late_a: assert property (
    atr_timeout |-> wait_q inside {[ATR_MAX-1:ATR_MAX+1]}) else $error("window end");
  deact_start_a: assert property (s_no_answer |-> ##[1:1000] deact_done)
    else $error("no deactivation");
  deact_off_a: assert property (
    deact_done |=> !card_vcc_en && card_io_oe && !card_reset_contact) else $error("off");
  rst_first_a: assert property ($fell(card_vcc_en) |-> !card_reset_contact)
    else $error("order");
endmodule
bind card_reset_seq card_seq_chk #(.RST_HOLD(RST_HOLD), .ATR_MIN(ATR_MIN), .ATR_MAX(ATR_MAX))
  chk (.clk, .reset, .card_clock_out, .card_reset_contact, .card_io_oe, .card_vcc_en, .atr_ok,
  .atr_timeout, .deact_done);

// >>> verif/card_reset_seq_bench.sv
// Self-checking bench for the card reset sequencer
module card_reset_seq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, reset = 1'h1, cold_start = 1'h0, warm_start = 1'h0, deact_req = 1'h0;
  logic [15:0] answer_at = 16'h0014;
  wire card_clock_out, card_reset_contact, card_io_out, card_io_oe, card_vcc_en, busy;
  wire atr_ok, atr_timeout, deact_done, pull_low;
  int fail_count = 0, comparisons = 0, cycles = 0;
  // Pulled-up open-drain line
  wire card_io_in = !(card_io_oe && !card_io_out) && !pull_low;
  wire [2:0] ev = {deact_done, atr_timeout, atr_ok};
  card_reset_seq #(.RST_HOLD(50), .ATR_MIN(5), .ATR_MAX(100), .DEACT_STEP(2)) dut (.clk, .reset,
    .cold_start, .warm_start, .deact_req, .card_io_in, .card_clock_out, .card_reset_contact,
    .card_io_out, .card_io_oe, .card_vcc_en, .busy, .atr_ok, .atr_timeout, .deact_done);
  card_model card (.clk, .card_clock_out, .card_reset_contact, .answer_at, .pull_low);
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(string what, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task wait_ev(int k, string what);
    for (int i = 0; i < 3000 && ev[k] !== 1'h1; i++)
      @(negedge clk);
    chk(what, 1'h1, ev[k]);
  endtask
  task start(logic warm);
    @(posedge clk);
    cold_start <= !warm;
    warm_start <= warm;
    @(posedge clk);
    cold_start <= 1'h0;
    warm_start <= 1'h0;
  endtask
  task cold_ok;
    start(1'h0);
    @(negedge clk);
    chk("busy", 1'h1, busy);
    chk("vcc_en", 1'h1, card_vcc_en);
    wait_ev(0, "atr_ok");
    chk("busy", 1'h0, busy);
    chk("reset_contact", 1'h1, card_reset_contact);
    chk("io_oe", 1'h0, card_io_oe);
    $display("cold_ok done");
  endtask
  task warm_ok;
    answer_at <= 16'h0006;
    start(1'h1);
    repeat (20) @(negedge clk);
    chk("reset_contact", 1'h0, card_reset_contact);
    wait_ev(0, "atr_ok");
    chk("io_oe", 1'h0, card_io_oe);
    $display("warm_ok done");
  endtask
  task stop_req;
    @(posedge clk);
    deact_req <= 1'h1;
    wait_ev(2, "deact_done");
    @(posedge clk);
    deact_req <= 1'h0;
    @(negedge clk);
    chk("vcc_en", 1'h0, card_vcc_en);
    $display("stop_req done");
  endtask
  task no_answer;
    answer_at <= 16'h0001;
    start(1'h0);
    wait_ev(1, "atr_timeout");
    wait_ev(2, "deact_done");
    chk("reset_contact", 1'h0, card_reset_contact);
    chk("io_out", 1'h0, card_io_out);
    @(negedge clk);
    chk("io_oe", 1'h1, card_io_oe);
    $display("no_answer done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    cold_ok;
    warm_ok;
    stop_req;
    no_answer;
    report_and_stop;
  end
endmodule
